// ==== rtl/tpe_prog_store.sv ====
// Operation
// - Erase command deletes all steps of program
// - Step-count query returns program step total
// - Insert carries program, step, mode, memory
// - Insert switches display to program edit
// - One shared pool of 500 steps
// - Remove command deletes one given step
// - Running-step query returns executing step number
// - Register writes take hex after marker, else decimal
// - Register queries answer in decimal only
// - Register bit one means set, zero cleared
// - Enable register contents are not retained
// - Request bit set on request, cleared by poll
// - Status query bit 6 reports master summary
// - Bit 5 summarises event status register
// - Bit 4 summarises device status register
// - Bits 7,3,2,1,0 read zero, ignore writes
// - Bad or out-of-range message flags command error; removing a step the program does not hold is ignored without error
`timescale 1ns/10ps
`default_nettype none

module tpe_prog_store
	import tpe_pkg::*;
#(
	parameter int NPROG = NUM_PROG,
	parameter int DEPTH = POOL_DEPTH
) (
	// Clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	// Parsed command
	input  wire logic        cmd_valid_in,
	input  wire tpe_op_t     cmd_op_in,
	input  wire logic [6:0]  cmd_prog_in,
	input  wire logic [6:0]  cmd_step_in,
	input  wire logic [1:0]  cmd_mode_in,
	input  wire logic [6:0]  cmd_mem_in,
	input  wire logic        cmd_hex_in,
	input  wire logic [11:0] cmd_digits_in,
	// Response
	output logic             rsp_valid_out,
	output logic [11:0]      rsp_bcd_out,
	output logic             cmd_error_out,
	// Sequencer side
	input  wire logic [6:0]  run_step_in,
	input  wire logic [6:0]  lkp_prog_in,
	input  wire logic [6:0]  lkp_step_in,
	output logic             lkp_hit_out,
	output logic [1:0]       lkp_mode_out,
	output logic [6:0]       lkp_mem_out,
	// Display
	input  wire logic        disp_leave_in,
	output logic             edit_screen_out,
	// Status summary
	input  wire logic        event_any_in,
	input  wire logic        device_any_in,
	input  wire logic        serial_poll_in,
	output logic [7:0]       poll_byte_out,
	output logic [7:0]       service_request_mask_out,
	output logic             srq_out,
	output logic             pool_full_out
);

	// ************************************************************
	// Storage
	// ************************************************************
	logic [DEPTH-1:0] ent_vld_ff;
	logic [6:0]       ent_prog_ff [DEPTH];
	logic [6:0]       ent_step_ff [DEPTH];
	logic [1:0]       ent_mode_ff [DEPTH];
	logic [6:0]       ent_mem_ff  [DEPTH];
	logic [6:0]       cnt_ff      [NPROG];
	logic [8:0]       used_ff;
	logic [7:0]       sre_ff;
	logic             rqs_ff;
	logic [7:0]       req_d_ff;
	tpe_disp_t        disp_ff;

	// ************************************************************
	// Command decode
	// ************************************************************
	logic       do_erase;
	logic       do_insert;
	logic       do_remove;
	logic       do_sre_wr;
	logic       bad_prog;
	logic       bad_args;
	logic       step_exists;
	logic       is_append;
	logic       pool_full;
	logic       val_bad;
	logic [9:0] val_num;
	logic [6:0] cur_cnt;
	logic [8:0] free_idx;

	assign cur_cnt     = cnt_ff[cmd_prog_in];
	assign step_exists = cmd_step_in < cur_cnt;
	assign is_append   = cmd_step_in == cur_cnt;
	assign pool_full   = used_ff >= 9'(DEPTH);
	assign bad_prog    = cmd_prog_in > MAX_PROG;

	always_comb begin
		bad_args = bad_prog;
		case (cmd_op_in)
			OP_INSERT: begin
				bad_args = bad_prog | (cmd_step_in > MAX_STEP) | (cmd_mem_in > MAX_MEM)
					| !(step_exists | (is_append & !pool_full));
			end
			OP_REMOVE: begin
				bad_args = bad_prog | (cmd_step_in > MAX_STEP);
			end
			OP_SRE_WR: begin
				bad_args = val_bad;
			end
			OP_RUN_Q, OP_SRE_Q, OP_STB_Q: begin
				bad_args = 1'b0;
			end
			default: begin
				bad_args = bad_prog;
			end
		endcase
	end

	assign do_erase  = cmd_valid_in & !bad_args & (cmd_op_in == OP_ERASE);
	assign do_insert = cmd_valid_in & !bad_args & (cmd_op_in == OP_INSERT);
	assign do_remove = cmd_valid_in & !bad_args & (cmd_op_in == OP_REMOVE) & step_exists;
	assign do_sre_wr = cmd_valid_in & !bad_args & (cmd_op_in == OP_SRE_WR);

	// ************************************************************
	// Value entry: hex after marker, decimal digits otherwise
	// ************************************************************
	always_comb begin
		if (cmd_hex_in) begin
			val_num = {2'b00, cmd_digits_in[7:0]};
			val_bad = cmd_digits_in[11:8] != 4'h0;
		end else begin
			val_num = 10'(cmd_digits_in[11:8]) * 10'h064 + 10'(cmd_digits_in[7:4]) * 10'h00a
				+ 10'(cmd_digits_in[3:0]);
			val_bad = (cmd_digits_in[11:8] > DEC_DIGIT_MAX) | (cmd_digits_in[7:4] > DEC_DIGIT_MAX)
				| (cmd_digits_in[3:0] > DEC_DIGIT_MAX) | (val_num > BYTE_MAX);
		end
	end

	// ************************************************************
	// Free slot search
	// ************************************************************
	always_comb begin
		free_idx = '0;
		for (int i = DEPTH - 1; i >= 0; i--) begin
			if (!ent_vld_ff[i]) begin
				free_idx = 9'(i);
			end
		end
	end

	// ************************************************************
	// Pool entries
	// ************************************************************
	for (genvar g = 0; g < DEPTH; g++) begin : g_ent
		logic own;
		assign own = ent_vld_ff[g] & (ent_prog_ff[g] == cmd_prog_in);

		always_ff @(posedge clk_sys_in) begin
			if (rst_in) begin
				ent_vld_ff[g]  <= 1'b0;
				ent_prog_ff[g] <= '0;
				ent_step_ff[g] <= '0;
				ent_mode_ff[g] <= '0;
				ent_mem_ff[g]  <= '0;
			end else if (do_erase && own) begin
				ent_vld_ff[g] <= 1'b0;
			end else if (do_remove && own) begin
				if (ent_step_ff[g] == cmd_step_in) begin
					ent_vld_ff[g] <= 1'b0;
				end else if (ent_step_ff[g] > cmd_step_in) begin
					ent_step_ff[g] <= ent_step_ff[g] - 7'h01; // Keeps numbering gap-free
				end
			end else if (do_insert && step_exists && own && ent_step_ff[g] == cmd_step_in) begin
				ent_mode_ff[g] <= cmd_mode_in;
				ent_mem_ff[g]  <= cmd_mem_in;
			end else if (do_insert && !step_exists && free_idx == 9'(g)) begin
				ent_vld_ff[g]  <= 1'b1;
				ent_prog_ff[g] <= cmd_prog_in;
				ent_step_ff[g] <= cmd_step_in;
				ent_mode_ff[g] <= cmd_mode_in;
				ent_mem_ff[g]  <= cmd_mem_in;
			end
		end
	end

	// ************************************************************
	// Per-program counts and pool usage
	// ************************************************************
	for (genvar p = 0; p < NPROG; p++) begin : g_cnt
		always_ff @(posedge clk_sys_in) begin
			if (rst_in) begin
				cnt_ff[p] <= '0;
			end else if (cmd_prog_in == 7'(p)) begin
				if (do_erase) begin
					cnt_ff[p] <= '0;
				end else if (do_remove) begin
					cnt_ff[p] <= cnt_ff[p] - 7'h01;
				end else if (do_insert && !step_exists) begin
					cnt_ff[p] <= cnt_ff[p] + 7'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			used_ff <= '0;
		end else if (do_erase) begin
			used_ff <= used_ff - {2'b00, cur_cnt};
		end else if (do_remove) begin
			used_ff <= used_ff - 9'h001;
		end else if (do_insert && !step_exists) begin
			used_ff <= used_ff + 9'h001;
		end
	end

	assign pool_full_out = pool_full;

	// ************************************************************
	// Sequencer lookup, registered
	// ************************************************************
	logic       lk_hit;
	logic [1:0] lk_mode;
	logic [6:0] lk_mem;

	always_comb begin
		lk_hit  = 1'b0;
		lk_mode = '0;
		lk_mem  = '0;
		for (int i = 0; i < DEPTH; i++) begin
			if (ent_vld_ff[i] && ent_prog_ff[i] == lkp_prog_in && ent_step_ff[i] == lkp_step_in) begin
				lk_hit  = 1'b1;
				lk_mode = ent_mode_ff[i];
				lk_mem  = ent_mem_ff[i];
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			lkp_hit_out  <= 1'b0;
			lkp_mode_out <= '0;
			lkp_mem_out  <= '0;
		end else begin
			lkp_hit_out  <= lk_hit;
			lkp_mode_out <= lk_mode;
			lkp_mem_out  <= lk_mem;
		end
	end

	// ************************************************************
	// Display state
	// ************************************************************
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			disp_ff <= DISP_OTHER;
		end else begin
			case (disp_ff)
				DISP_OTHER: begin
					if (do_insert) begin
						disp_ff <= DISP_EDIT;
					end
				end
				DISP_EDIT: begin
					if (disp_leave_in && !do_insert) begin
						disp_ff <= DISP_OTHER;
					end
				end
				default: begin
					disp_ff <= DISP_OTHER;
				end
			endcase
		end
	end

	assign edit_screen_out = disp_ff == DISP_EDIT;

	// ************************************************************
	// Status byte and request logic
	// ************************************************************
	logic [7:0] stb_raw;
	logic       master_summary_flag;

	// Only bits 5 and 4 exist; the rest are forced low
	assign stb_raw = {2'b00, event_any_in, device_any_in, 4'h0} & STB_USED_MASK;
	assign master_summary_flag     = |(stb_raw & sre_ff);

	// Not backed up, so power-on always starts cleared
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			sre_ff <= SRE_RESET;
		end else if (do_sre_wr) begin
			sre_ff <= val_num[7:0] & STB_USED_MASK;
		end
	end

	// Each enabled bit requests on its own rise; a rise in a poll cycle wins
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rqs_ff   <= 1'b0;
			req_d_ff <= '0;
		end else begin
			req_d_ff <= stb_raw & sre_ff;
			if (|(stb_raw & sre_ff & ~req_d_ff)) begin
				rqs_ff <= 1'b1;
			end else if (serial_poll_in) begin
				rqs_ff <= 1'b0;
			end
		end
	end

	assign srq_out                  = rqs_ff;
	assign service_request_mask_out = sre_ff;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			poll_byte_out <= '0;
		end else if (serial_poll_in) begin
			poll_byte_out <= stb_raw | {1'b0, rqs_ff, 6'h00};
		end
	end

	// ************************************************************
	// Responses, always decimal
	// ************************************************************
	function automatic logic [11:0] to_bcd(input logic [7:0] v);
		logic [3:0] h;
		logic [3:0] t;
		logic [3:0] o;
		h = 4'(v / 8'd100);
		t = 4'((v % 8'd100) / 8'd10);
		o = 4'(v % 8'd10);
		return {h, t, o};
	endfunction

	logic [7:0] rsp_bin;

	always_comb begin
		case (cmd_op_in)
			OP_COUNT_Q: begin
				rsp_bin = {1'b0, cur_cnt};
			end
			OP_RUN_Q: begin
				rsp_bin = {1'b0, run_step_in};
			end
			OP_SRE_Q: begin
				rsp_bin = sre_ff;
			end
			OP_STB_Q: begin
				rsp_bin = stb_raw | {1'b0, master_summary_flag, 6'h00};
			end
			default: begin
				rsp_bin = '0;
			end
		endcase
	end

	logic is_query;
	assign is_query = (cmd_op_in == OP_COUNT_Q) | (cmd_op_in == OP_RUN_Q)
		| (cmd_op_in == OP_SRE_Q) | (cmd_op_in == OP_STB_Q);

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rsp_valid_out <= 1'b0;
			rsp_bcd_out   <= '0;
			cmd_error_out <= 1'b0;
		end else begin
			rsp_valid_out <= cmd_valid_in & is_query & !bad_args;
			cmd_error_out <= cmd_valid_in & bad_args;
			if (cmd_valid_in && is_query && !bad_args) begin
				rsp_bcd_out <= to_bcd(rsp_bin);
			end
		end
	end

endmodule

`default_nettype wire

// ==== rtl/tpe_pkg.sv ====
package tpe_pkg;

	// ************************************************************
	// Store geometry
	// ************************************************************
	localparam int          NUM_PROG      = 100;
	localparam int          POOL_DEPTH    = 500;
	localparam logic [6:0]  MAX_PROG      = 7'h63;
	localparam logic [6:0]  MAX_STEP      = 7'h63;
	localparam logic [6:0]  MAX_MEM       = 7'h63;

	// ************************************************************
	// Status byte layout
	// ************************************************************
	localparam int          STB_RQS_BIT   = 6;
	localparam int          STB_ESB_BIT   = 5;
	localparam int          STB_DSB_BIT   = 4;
	localparam logic [7:0]  STB_USED_MASK = 8'h30;
	localparam logic [7:0]  SRE_RESET     = 8'h00;

	// ************************************************************
	// Value entry
	// ************************************************************
	localparam logic [3:0]  DEC_DIGIT_MAX = 4'h9;
	localparam logic [9:0]  BYTE_MAX      = 10'h0ff;

	// ************************************************************
	// Commands and queries, one-hot
	// ************************************************************
	typedef enum logic [7:0] {
		OP_ERASE   = 8'h01,
		OP_COUNT_Q = 8'h02,
		OP_INSERT  = 8'h04,
		OP_REMOVE  = 8'h08,
		OP_RUN_Q   = 8'h10,
		OP_SRE_WR  = 8'h20,
		OP_SRE_Q   = 8'h40,
		OP_STB_Q   = 8'h80
	} tpe_op_t;

	// ************************************************************
	// Test modes
	// ************************************************************
	typedef enum logic [1:0] {
		ac_withstand_mode          = 2'h0,
		dc_withstand_mode          = 2'h1,
		insulation_resistance_mode = 2'h2,
		earth_continuity_mode      = 2'h3
	} tpe_mode_t;

	// ************************************************************
	// Display state
	// ************************************************************
	typedef enum logic [1:0] {
		DISP_OTHER = 2'b01,
		DISP_EDIT  = 2'b10
	} tpe_disp_t;

endpackage

// ==== test/tpe_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module tpe_monitor
	import tpe_pkg::*;
#(
	parameter int NPROG = NUM_PROG,
	parameter int DEPTH = POOL_DEPTH
) (
	// Clock and reset
	input wire logic       clk_sys_in,
	input wire logic       rst_in,
	// Commands
	input wire logic       cmd_valid_in,
	input wire tpe_op_t    cmd_op_in,
	input wire logic [6:0] cmd_prog_in,
	input wire logic       cmd_error_out,
	input wire logic       rsp_valid_out,
	input wire logic       edit_screen_out,
	// Status
	input wire logic       event_any_in,
	input wire logic       device_any_in,
	input wire logic       serial_poll_in,
	input wire logic [7:0] poll_byte_out,
	input wire logic [7:0] service_request_mask_out,
	input wire logic       srq_out
);
	// ****
	// Summary
	// ****
	logic msum;
	logic ev_m;
	logic dv_m;
	assign ev_m = event_any_in & service_request_mask_out[5];
	assign dv_m = device_any_in & service_request_mask_out[4];
	assign msum = ev_m | dv_m;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	sequence s_insert;
		cmd_valid_in && cmd_op_in == OP_INSERT;
	endsequence
	sequence s_query;
		cmd_valid_in && (cmd_op_in == OP_RUN_Q || cmd_op_in == OP_STB_Q || cmd_op_in == OP_SRE_Q);
	endsequence
	sequence s_poll;
		serial_poll_in && !$rose(ev_m) && !$rose(dv_m);
	endsequence
	// ****
	// Checks
	// ****
	edit_after_insert_a: assert property (s_insert ##1 !cmd_error_out |-> edit_screen_out)
		else $error("no edit screen after insert");
	erase_range_a: assert property (cmd_valid_in && cmd_op_in == OP_ERASE && cmd_prog_in > MAX_PROG |=> cmd_error_out)
		else $error("bad program not refused");
	query_answer_a: assert property (s_query |=> rsp_valid_out && !cmd_error_out)
		else $error("query not answered");
	mask_unused_a: assert property ((service_request_mask_out & ~STB_USED_MASK) == 8'h00)
		else $error("unused mask bit set");
	poll_unused_a: assert property ((poll_byte_out & 8'h8f) == 8'h00)
		else $error("unused status bit set");
	srq_raise_a: assert property ($rose(msum) |=> srq_out)
		else $error("request not raised");
	srq_bit_rise_a: assert property ($rose(ev_m) || $rose(dv_m) |=> srq_out)
		else $error("enabled bit rise gave no request");
	srq_hold_a: assert property (srq_out && !serial_poll_in |=> srq_out)
		else $error("request dropped without poll");
	poll_clear_a: assert property (s_poll |=> !srq_out)
		else $error("poll left request set");
	poll_capture_a: assert property (serial_poll_in |=> poll_byte_out[6:4] == {$past(srq_out), $past(event_any_in), $past(device_any_in)})
		else $error("poll byte wrong");
	reset_mask_a: assert property (disable iff (1'b0) rst_in |=> service_request_mask_out == SRE_RESET && !srq_out)
		else $error("mask not cleared by reset");
endmodule
`default_nettype wire

// ==== test/tpe_ctrl_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module tpe_ctrl_model
	import tpe_pkg::*;
(
	// Clock
	input  wire logic   clk_sys_in,
	// Command wires
	output logic        valid_out,
	output tpe_op_t     op_out,
	output logic [6:0]  prog_out,
	output logic [6:0]  step_out,
	output logic [1:0]  mode_out,
	output logic [6:0]  mem_out,
	output logic        hex_out,
	output logic [11:0] dig_out
);
	initial begin
		{valid_out, prog_out, step_out, mode_out, mem_out, hex_out, dig_out} = '0;
		op_out = OP_RUN_Q;
	end
	// One command per pulse; fields held through the taking edge
	task automatic send(input tpe_op_t op, input logic [6:0] p, input logic [6:0] s,
		input logic [1:0] m, input logic [6:0] k, input logic h, input logic [11:0] d);
		@(posedge clk_sys_in);
		valid_out <= 1'b1;
		op_out <= op;
		{prog_out, step_out, mode_out, mem_out, hex_out, dig_out} <= {p, s, m, k, h, d};
		@(posedge clk_sys_in);
		valid_out <= 1'b0;
		// Released program, step, memory and digit fields turn over so a stale value can never be mistaken for live data
		{prog_out, step_out, mem_out, dig_out} <= ~{p, s, k, d};
	endtask
endmodule
`default_nettype wire

// ==== test/test_program_edit_and_status_byte_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_program_edit_and_status_byte_tb;
	import tpe_pkg::*;
	localparam int ERR = 4096;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic c_valid, c_hex, rsp_v, c_err, hit, edit, srq, full;
	logic ev_any = 1'b0, dv_any = 1'b0, poll = 1'b0, leave = 1'b0;
	tpe_op_t c_op;
	logic [6:0] c_prog, c_step, c_mem, l_mem;
	logic [6:0] run_step = 7'h00, lkp_prog = 7'h00, lkp_step = 7'h00;
	logic [1:0] c_mode, l_mode;
	logic [11:0] c_dig, rsp_bcd;
	logic [7:0] poll_byte, mask;
	logic [15:0] rnd = 16'h0219;
	int err_count = 0, checked = 0, cycles = 0;
	int mems [4];
	int notes [$];
	logic [11:0] sre_dig [5] = '{12'h048, 12'h00ff, 12'h010, 12'h0256, 12'h00a0};
	logic sre_hex [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
	int sre_exp [5] = '{72, 72, 22, 22, 22};
	always #5 clk_sys_in = ~clk_sys_in;
	tpe_ctrl_model u_ctrl (.clk_sys_in(clk_sys_in), .valid_out(c_valid), .op_out(c_op),
		.prog_out(c_prog), .step_out(c_step), .mode_out(c_mode), .mem_out(c_mem),
		.hex_out(c_hex), .dig_out(c_dig));
	tpe_prog_store #(.NPROG(100), .DEPTH(8)) u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.cmd_valid_in(c_valid), .cmd_op_in(c_op), .cmd_prog_in(c_prog), .cmd_step_in(c_step),
		.cmd_mode_in(c_mode), .cmd_mem_in(c_mem), .cmd_hex_in(c_hex), .cmd_digits_in(c_dig),
		.rsp_valid_out(rsp_v), .rsp_bcd_out(rsp_bcd), .cmd_error_out(c_err),
		.run_step_in(run_step), .lkp_prog_in(lkp_prog), .lkp_step_in(lkp_step),
		.lkp_hit_out(hit), .lkp_mode_out(l_mode), .lkp_mem_out(l_mem),
		.disp_leave_in(leave), .edit_screen_out(edit), .event_any_in(ev_any),
		.device_any_in(dv_any), .serial_poll_in(poll), .poll_byte_out(poll_byte),
		.service_request_mask_out(mask), .srq_out(srq), .pool_full_out(full));
	// ****
	// Helpers
	// ****
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic int bcd(input int v);
		return (v / 100) * 256 + (v / 10 % 10) * 16 + v % 10;
	endfunction
	task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input tpe_op_t op, input int p, input int s, input int m, input int k,
		input logic h, input logic [11:0] d, input int note);
		if (note >= 0) notes.push_back(note);
		u_ctrl.send(op, 7'(p), 7'(s), 2'(m), 7'(k), h, d);
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic look(input int s, input int m, input int k);
		@(posedge clk_sys_in);
		lkp_prog <= 7'h0a;
		lkp_step <= 7'(s);
		settle(2);
		chk({3'h0, hit, l_mode, l_mem}, {3'h0, 1'b1, 2'(m), 7'(k)});
	endtask
	// Oldest note pairs with each answer as it appears
	always @(negedge clk_sys_in) begin
		if (!rst_in && (rsp_v !== 1'b0 || c_err !== 1'b0)) begin
			if (notes.size() == 0) chk(13'h1fff, 13'h0000);
			else chk({c_err, c_err ? 12'h000 : rsp_bcd}, 13'(notes.pop_front()));
		end
	end
	always @(posedge clk_sys_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			end_sim();
		end
	end
	// ****
	// Scenarios
	// ****
	initial begin
		repeat (5) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		settle(1);
		chk({5'h00, mask}, 13'h0000);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			mems[i] = rnd % 100;
			cmd(OP_INSERT, 10, i, i, mems[i], 1'b0, 12'h000, -1);
			settle(1);
			chk({12'h000, edit}, 13'h0001);
		end
		@(posedge clk_sys_in);
		leave <= 1'b1;
		@(posedge clk_sys_in);
		leave <= 1'b0;
		settle(1);
		chk({12'h000, edit}, 13'h0000);
		for (int i = 0; i < 4; i++) look(i, i, mems[i]);
		cmd(OP_COUNT_Q, 10, 0, 0, 0, 1'b0, 12'h000, bcd(4));
		cmd(OP_INSERT, 10, 6, 0, 1, 1'b0, 12'h000, ERR);
		cmd(OP_INSERT, 100, 0, 0, 1, 1'b0, 12'h000, ERR);
		cmd(OP_REMOVE, 10, 0, 0, 0, 1'b0, 12'h000, -1);
		cmd(OP_REMOVE, 10, 50, 0, 0, 1'b0, 12'h000, -1);
		cmd(OP_COUNT_Q, 10, 0, 0, 0, 1'b0, 12'h000, bcd(3));
		look(0, 1, mems[1]);
		cmd(OP_ERASE, 10, 0, 0, 0, 1'b0, 12'h000, -1);
		cmd(OP_COUNT_Q, 10, 0, 0, 0, 1'b0, 12'h000, bcd(0));
		cmd(OP_ERASE, 100, 0, 0, 0, 1'b0, 12'h000, ERR);
		cmd(OP_COUNT_Q, 120, 0, 0, 0, 1'b0, 12'h000, ERR);
		rnd = lfsr(rnd);
		@(posedge clk_sys_in);
		run_step <= 7'(rnd % 100);
		cmd(OP_RUN_Q, 0, 0, 0, 0, 1'b0, 12'h000, bcd(rnd % 100));
		for (int i = 0; i < 5; i++) begin
			cmd(OP_SRE_WR, 0, 0, 0, 0, sre_hex[i], sre_dig[i], (i > 2) ? ERR : -1);
			cmd(OP_SRE_Q, 0, 0, 0, 0, 1'b0, 12'h000, sre_exp[i]);
		end
		cmd(OP_SRE_WR, 0, 0, 0, 0, 1'b1, 12'h030, -1);
		@(posedge clk_sys_in);
		ev_any <= 1'b1;
		settle(2);
		chk({12'h000, srq}, 13'h0001);
		cmd(OP_STB_Q, 0, 0, 0, 0, 1'b0, 12'h000, bcd(96));
		@(posedge clk_sys_in);
		poll <= 1'b1;
		@(posedge clk_sys_in);
		poll <= 1'b0;
		settle(1);
		chk({4'h0, srq, poll_byte}, {5'h00, 8'h60});
		@(posedge clk_sys_in);
		dv_any <= 1'b1;
		settle(2);
		chk({12'h000, srq}, 13'h0001);
		cmd(OP_STB_Q, 0, 0, 0, 0, 1'b0, 12'h000, bcd(112));
		for (int i = 0; i < 8; i++) cmd(OP_INSERT, 20, i, 0, i, 1'b0, 12'h000, -1);
		settle(1);
		chk({12'h000, full}, 13'h0001);
		cmd(OP_INSERT, 21, 0, 1, 0, 1'b0, 12'h000, ERR);
		cmd(OP_ERASE, 20, 0, 0, 0, 1'b0, 12'h000, -1);
		settle(2);
		chk({12'h000, full}, 13'h0000);
		chk(13'(notes.size()), 13'h0000);
		end_sim();
	end
endmodule
bind tpe_prog_store tpe_monitor #(.NPROG(NPROG), .DEPTH(DEPTH)) u_mon (
	.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
	.cmd_op_in(cmd_op_in), .cmd_prog_in(cmd_prog_in), .cmd_error_out(cmd_error_out),
	.rsp_valid_out(rsp_valid_out), .edit_screen_out(edit_screen_out),
	.event_any_in(event_any_in), .device_any_in(device_any_in),
	.serial_poll_in(serial_poll_in), .poll_byte_out(poll_byte_out),
	.service_request_mask_out(service_request_mask_out), .srq_out(srq_out));
`default_nettype wire
